// >>> hdl/expri_unit.sv
// Chosen here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "expri_defs.svh"
module expri_unit
    import expri_pkg::*;
#(
    parameter int NREG = 32
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    // wishbone slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [5:2]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    // exception requests
    input  wire logic             cpu_reset_req,
    input  wire logic             hw_break,
    input  wire logic             irq_internal,
    input  wire logic             eic_nmi,
    input  wire logic             eic_irq,
    input  wire logic [31:0]      eic_handler,
    input  wire logic             inst_valid,
    input  wire expri_src_t       src,
    // register file traffic
    input  wire expri_rfw_t       rf_wr,
    input  wire logic             rf_rd_en,
    input  wire logic [4:0]       rf_rd_idx,
    // tlb traffic
    input  wire logic             tlb_wr,
    input  wire logic [5:0]       tlb_wr_idx,
    input  wire logic             tlb_hw_rd,
    input  wire logic [5:0]       tlb_rd_idx,
    // results
    output logic                  exc_take,
    output logic      [31:0]      exc_vector,
    output logic                  utlb_flush,
    output logic      [5:0]       utlb_flush_idx
);
    parameter logic [31:0] RESET_ADDR = 32'h0000_0000;
    parameter logic [31:0] BREAK_ADDR = 32'h0000_0020;
    parameter logic [31:0] EXC_ADDR   = 32'h0000_0040;
    parameter logic [31:0] FAST_ADDR  = 32'h0000_0080;

    // elaboration check: the index ports are sized for 32 registers
    if (NREG != 32) begin : g_bad_nreg
        $error("expri_unit supports 32 registers only");
    end

    ////////////////////////////////////////////////////////////////////////
    logic [31:0] status_reg;
    logic [4:0]  cause_reg;
    logic [31:0] retaddr_reg;
    logic [19:0] vpn_reg;
    logic [31:0] vector_reg;
    logic [3:0]  inject_reg;
    logic        tlb_ee_reg;
    logic        in_miss_reg;
    logic        take_reg;
    logic [1:0]  rf_bad_reg [NREG];
    logic [1:0]  tlb_bad_reg [64];
    logic        bus_req;
    logic        rf_ecc_err;
    logic        tlb_ecc_hw;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // only double-bit errors are uncorrectable; single bits get fixed
    assign rf_ecc_err = rf_rd_en && rf_rd_idx != 5'h00 &&
                        rf_bad_reg[rf_rd_idx] == `EXPRI_INJ_DOUBLE; // see RL3
    assign tlb_ecc_hw = tlb_hw_rd &&
                        tlb_bad_reg[tlb_rd_idx] == `EXPRI_INJ_DOUBLE; // see RL6

    ////////////////////////////////////////////////////////////////////////
    // per-register error marks; write clears unless injection armed
    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_rf
            always_ff @(posedge clk) begin
                if (srst) begin
                    rf_bad_reg[gi] <= `EXPRI_INJ_NONE;
                end else if (rf_wr.en && rf_wr.idx == 5'(gi) && gi != 0) begin
                    rf_bad_reg[gi] <= inject_reg[1:0]; // see RL1
                end
            end
        end
        for (gi = 0; gi < 64; gi++) begin : g_tlb
            always_ff @(posedge clk) begin
                if (srst) begin
                    tlb_bad_reg[gi] <= `EXPRI_INJ_NONE;
                end else if (tlb_wr && tlb_wr_idx == 6'(gi)) begin
                    tlb_bad_reg[gi] <= inject_reg[3:2]; // see RL4
                end
            end
        end
    endgenerate

    // injection control: hardware disarm beats a software write
    always_ff @(posedge clk) begin
        if (srst) begin
            inject_reg <= 4'h0; // see RL22
        end else begin
            if (bus_req && wb_we_i && wb_sel_i[0] &&
                wb_adr_i == `EXPRI_ADR_INJECT)
                inject_reg <= wb_dat_i[3:0];
            if (rf_wr.en && rf_wr.idx != 5'h00)
                inject_reg[1:0] <= `EXPRI_INJ_NONE; // see RL2
            if (tlb_wr)
                inject_reg[3:2] <= `EXPRI_INJ_NONE; // see RL5
        end
    end

    // micro-tlb flush on every entry write, so no stale copy survives
    always_ff @(posedge clk) begin
        if (srst) begin
            utlb_flush     <= 1'b0;
            utlb_flush_idx <= 6'h00;
        end else begin
            utlb_flush     <= tlb_wr; // see RL4
            utlb_flush_idx <= tlb_wr_idx;
        end
    end

    // software tlb read: error flag visible on the next access
    always_ff @(posedge clk) begin
        if (srst) begin
            tlb_ee_reg <= 1'b0;
        end else if (bus_req && wb_we_i && wb_sel_i[0] &&
                     wb_adr_i == `EXPRI_ADR_TLB_MISC_CONTROL) begin
            if (wb_dat_i[`EXPRI_TLB_RD_BIT])
                tlb_ee_reg <= tlb_bad_reg[tlb_rd_idx] ==
                              `EXPRI_INJ_DOUBLE; // see RL7
            else
                tlb_ee_reg <= wb_dat_i[`EXPRI_TLB_EE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // priority resolution
    logic        sel_take;
    logic        sel_cause_wr;
    logic [4:0]  sel_cause;
    logic [31:0] sel_vec;
    logic        sel_vpn_wr;
    logic        sel_miss;

    always_comb begin
        sel_take     = 1'b1;
        sel_cause_wr = 1'b1;
        sel_cause    = `EXPRI_C_RESET;
        sel_vec      = EXC_ADDR;
        sel_vpn_wr   = 1'b0;
        sel_miss     = 1'b0;
        // fixed descending order; first hit wins, see RL12
        if (hw_break) begin
            sel_cause_wr = 1'b0; // see RL10
            sel_vec      = BREAK_ADDR;
        end else if (cpu_reset_req) begin
            sel_cause = `EXPRI_C_CPURST; // see RL9
            sel_vec   = RESET_ADDR;
        end else if (irq_internal) begin
            sel_cause = `EXPRI_C_IRQ; // see RL14
        end else if (eic_nmi) begin
            sel_cause_wr = 1'b0; // see RL13
            sel_vec      = eic_handler;
        end else if (eic_irq) begin
            sel_cause = `EXPRI_C_IRQ; // see RL14
            sel_vec   = eic_handler;
        end else if (inst_valid && (src.tlb_ecc || tlb_ecc_hw)) begin
            sel_cause = `EXPRI_C_TLBECC; // see RL15
        end else if (inst_valid && src.sup_inst) begin
            sel_cause = `EXPRI_C_SUPI; // see RL16
        end else if (inst_valid && src.tlb_miss) begin
            sel_cause  = `EXPRI_C_TLBMISS;
            sel_vpn_wr = 1'b1;
            sel_miss   = 1'b1;
            // nested miss falls to the general handler
            sel_vec = in_miss_reg ? EXC_ADDR : FAST_ADDR; // see RL17 see RL18
        end else if (inst_valid && src.xperm) begin
            sel_cause  = `EXPRI_C_XPERM; // see RL19
            sel_vpn_wr = 1'b1;
        end else if (inst_valid && rf_ecc_err) begin
            sel_cause = `EXPRI_C_RFECC; // see RL20
        end else if (inst_valid && src.mpu_viol) begin
            sel_cause = `EXPRI_C_MPUI; // see RL11
        end else begin
            sel_take     = 1'b0;
            sel_cause_wr = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // exception state; faulting pc kept so the handler can re-run it
    always_ff @(posedge clk) begin
        if (srst) begin
            take_reg    <= 1'b1;
            vector_reg  <= RESET_ADDR; // see RL9
            cause_reg   <= `EXPRI_C_RESET;
            retaddr_reg <= 32'h0000_0000;
            vpn_reg     <= 20'h00000;
            in_miss_reg <= 1'b0;
        end else begin
            take_reg <= sel_take;
            if (sel_take) begin
                vector_reg  <= sel_vec;
                retaddr_reg <= src.pc; // see RL8
            end
            if (sel_cause_wr)
                cause_reg <= sel_cause; // see RL13
            if (sel_vpn_wr)
                vpn_reg <= src.vpn; // see RL17
            if (sel_miss)
                in_miss_reg <= 1'b1;
            else if (bus_req && wb_we_i && wb_adr_i == `EXPRI_ADR_STATUS)
                in_miss_reg <= 1'b0; // handler return via status write
        end
    end

    // status register
    always_ff @(posedge clk) begin
        if (srst) begin
            status_reg <= `EXPRI_STATUS_RST; // see RL21
        end else if (bus_req && wb_we_i && wb_sel_i == 4'hF &&
                     wb_adr_i == `EXPRI_ADR_STATUS) begin
            status_reg <= wb_dat_i;
        end
    end

    assign exc_take   = take_reg;
    assign exc_vector = vector_reg;

    ////////////////////////////////////////////////////////////////////////
    // wishbone read data and one-cycle ack
    always_ff @(posedge clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            case (wb_adr_i)
                `EXPRI_ADR_INJECT:  wb_dat_o <= {28'h0, inject_reg};
                `EXPRI_ADR_TLB_MISC_CONTROL: wb_dat_o <= {30'h0, tlb_ee_reg, 1'b0};
                `EXPRI_ADR_CAUSE:   wb_dat_o <= {27'h0, cause_reg};
                `EXPRI_ADR_STATUS:  wb_dat_o <= status_reg;
                `EXPRI_ADR_VECTOR:  wb_dat_o <= vector_reg;
                `EXPRI_ADR_RETADDR: wb_dat_o <= retaddr_reg;
                `EXPRI_ADR_VPN:     wb_dat_o <= {12'h0, vpn_reg};
                `EXPRI_ADR_PENDING: wb_dat_o <= {31'h0, in_miss_reg};
                default:            wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// >>> hdl/expri_defs.svh
// Contract
// RL1: armed regfile injection corrupts next write to any register except r0.
// RL2: regfile injection field returns to no-injection after injecting.
// RL3: injected uncorrectable error read on first source port raises exception.
// RL4: armed tlb injection corrupts next tlb entry write and flushes micro-tlb copy.
// RL5: tlb injection field returns to no-injection after injecting.
// RL6: hardware tlb read of bad entry traps on next instruction.
// RL7: software tlb read of bad entry sets tlb error flag after the write.
// RL8: every exception is precise; faulting instruction can be re-executed.
// RL9: reset and processor-only reset go to reset address, causes 0 and 1.
// RL10: hardware break goes to break address, no cause, ranks below reset; the code ranks it above processor-only reset.
// RL11: instruction exceptions except fast tlb miss use general exception address.
// RL12: pending exceptions resolve in the fixed descending priority order.
// RL13: each exception with a cause code writes it; break and nmi do not.
// RL14: internal irq cause 2 general; external maskable 2, nmi none, requested.
// RL15: instruction tlb ecc error records cause 18, general exception vector.
// RL16: user fetch from supervisor-only address records cause 9, general vector.
// RL17: instruction tlb miss outside exception: cause 12, capture vpn, fast vector.
// RL18: instruction tlb miss inside miss handling: cause 12, vpn, general vector.
// RL19: fetch without execute permission: cause 13, capture vpn, general vector.
// RL20: register-file ecc error: cause 20, report faulting address, general vector.
// RL21: reset sets shadow-set irq enable to one and clears other status fields.
// RL22: injection field encodings are chosen locally.
`ifndef EXPRI_DEFS_SVH
`define EXPRI_DEFS_SVH

// register word indices on wb_adr_i[5:2]
`define EXPRI_ADR_INJECT    4'h0
`define EXPRI_ADR_TLB_MISC_CONTROL   4'h1
`define EXPRI_ADR_CAUSE     4'h2
`define EXPRI_ADR_STATUS    4'h3
`define EXPRI_ADR_VECTOR    4'h4
`define EXPRI_ADR_RETADDR   4'h5
`define EXPRI_ADR_VPN       4'h6
`define EXPRI_ADR_PENDING   4'h7

// injection field positions and codes
`define EXPRI_RF_LSB        0
`define EXPRI_TLB_LSB       2
`define EXPRI_INJ_NONE      2'h0
`define EXPRI_INJ_SINGLE    2'h1
`define EXPRI_INJ_DOUBLE    2'h2

// tlb misc bits
`define EXPRI_TLB_RD_BIT    0
`define EXPRI_TLB_EE_BIT    1

// status reset value: shadow-set irq enable at bit 23
`define EXPRI_RSIE_BIT      23
`define EXPRI_STATUS_RST    32'h0080_0000

// cause codes
`define EXPRI_C_RESET       5'h00
`define EXPRI_C_CPURST      5'h01
`define EXPRI_C_IRQ         5'h02
`define EXPRI_C_SUPI        5'h09
`define EXPRI_C_TLBMISS     5'h0C
`define EXPRI_C_XPERM       5'h0D
`define EXPRI_C_MPUI        5'h10
`define EXPRI_C_TLBECC      5'h12
`define EXPRI_C_RFECC       5'h14

`endif

// >>> hdl/expri_pkg.sv
package expri_pkg;
    // vector selection
    typedef enum logic [4:0] {
        EXPRI_V_NONE  = 5'b00001,
        EXPRI_V_RESET = 5'b00010,
        EXPRI_V_BREAK = 5'b00100,
        EXPRI_V_GEN   = 5'b01000,
        EXPRI_V_FAST  = 5'b10000,
        EXPRI_V_EIC   = 5'b00011
    } expri_vec_t;

    // pipeline exception sources for the instruction in flight
    typedef struct packed {
        logic        tlb_ecc;
        logic        sup_inst;
        logic        tlb_miss;
        logic        xperm;
        logic        mpu_viol;
        logic [19:0] vpn;
        logic [31:0] pc;
    } expri_src_t;

    // register-file write port seen by the unit
    typedef struct packed {
        logic        en;
        logic [4:0]  idx;
        logic [31:0] data;
    } expri_rfw_t;
endpackage

// >>> bench/expri_eic_model.sv
`timescale 1ns/1ps
// far side: debug module break request and external irq controller
module expri_eic_model #(
    parameter logic [31:0] HANDLER = 32'h0000_0300
) (
    // command from the bench: bit0 break, bit1 nmi, bit2 irq
    input  logic [2:0]  cmd,
    // requests toward the unit
    output logic        hw_break,
    output logic        eic_nmi,
    output logic        eic_irq,
    output logic [31:0] eic_handler
);
    // levels held for as long as the bench commands them
    assign hw_break = cmd[0];
    assign eic_nmi  = cmd[1];
    assign eic_irq  = cmd[2];
    // address is only valid with a request; inverse otherwise, so a
    // late sample cannot match by luck
    assign eic_handler = (cmd[1] | cmd[2]) ? HANDLER : ~HANDLER;
endmodule

// >>> bench/expri_unit_asserts.sv
`timescale 1ns/1ps
module expri_unit_asserts
    import expri_pkg::*;
#(
    parameter logic [31:0] RESET_ADDR = 32'h0,
    parameter logic [31:0] BREAK_ADDR = 32'h20,
    parameter logic [31:0] EXC_ADDR   = 32'h40
) (
    // clock, reset and bus
    input logic        clk,
    input logic        srst,
    input logic        wb_cyc_i,
    input logic        wb_stb_i,
    input logic        wb_ack_o,
    // requests
    input logic        cpu_reset_req,
    input logic        hw_break,
    input logic        irq_internal,
    input logic        eic_nmi,
    input logic        eic_irq,
    input logic [31:0] eic_handler,
    input logic        inst_valid,
    input expri_src_t  src,
    input logic        tlb_wr,
    input logic [5:0]  tlb_wr_idx,
    // results
    input logic        exc_take,
    input logic [31:0] exc_vector,
    input logic        utlb_flush,
    input logic [5:0]  utlb_flush_idx
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // instruction checks exclude break, cpu reset and every interrupt request
    wire hi = hw_break | cpu_reset_req | irq_internal | eic_nmi | eic_irq;
    wire iv = inst_valid & ~hi;
    reset_vec_a: assert property (disable iff (1'b0)
        srst |=> exc_take && exc_vector == RESET_ADDR)
        else $error("reset vector missing");
    break_vec_a: assert property (hw_break
        |=> exc_take && exc_vector == BREAK_ADDR)
        else $error("break vector wrong");
    cpu_rst_a: assert property (cpu_reset_req && !hw_break
        |=> exc_take && exc_vector == RESET_ADDR)
        else $error("cpu reset vector wrong");
    nmi_vec_a: assert property (
        eic_nmi && !hw_break && !cpu_reset_req && !irq_internal
        |=> exc_take && exc_vector == $past(eic_handler))
        else $error("nmi vector wrong");
    tlb_ecc_a: assert property (iv && src.tlb_ecc
        |=> exc_take && exc_vector == EXC_ADDR)
        else $error("tlb ecc vector wrong");
    sup_fetch_a: assert property (iv && src.sup_inst
        |=> exc_take && exc_vector == EXC_ADDR)
        else $error("supervisor fetch vector wrong");
    xperm_vec_a: assert property (
        iv && src.xperm && !src.tlb_ecc && !src.sup_inst && !src.tlb_miss
        |=> exc_take && exc_vector == EXC_ADDR)
        else $error("execute permission vector wrong");
    utlb_flush_a: assert property (tlb_wr
        |=> utlb_flush && utlb_flush_idx == $past(tlb_wr_idx))
        else $error("micro tlb flush missing");
    ack_once_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle");
    // main scenarios reached
    brk_c: cover property (hw_break ##1 exc_take);
    nmi_c: cover property (eic_nmi ##1 exc_take);
    flush_c: cover property (tlb_wr ##1 utlb_flush);
endmodule
////////////////////////////////////////////////////////////////////////
bind expri_unit expri_unit_asserts #(
    .RESET_ADDR(RESET_ADDR),
    .BREAK_ADDR(BREAK_ADDR),
    .EXC_ADDR(EXC_ADDR)
) i_chk (
    .clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .cpu_reset_req,
    .hw_break, .irq_internal, .eic_nmi, .eic_irq, .eic_handler,
    .inst_valid, .src, .tlb_wr, .tlb_wr_idx, .exc_take, .exc_vector,
    .utlb_flush, .utlb_flush_idx
);

// >>> bench/expri_unit_tb.sv
`timescale 1ns/1ps
`include "expri_defs.svh"
module expri_unit_tb
    import expri_pkg::*;
;
    localparam logic [31:0] HND = 32'h0000_0300;
    localparam logic [31:0] BA = 32'h20, EA = 32'h40, FA = 32'h80;
    logic        clk = 1'b0, srst = 1'b1, cyc = 1'b0, we = 1'b0;
    logic [3:0]  adr = 4'h0, sel = 4'h0;
    logic [31:0] wd = 32'h0, q, rdat, vec, hdl;
    logic        ack, take, brk, nmi, irq, fl;
    logic        cpu_rst = 1'b0, irq_int = 1'b0, iv = 1'b0;
    logic        rd_en = 1'b0, tlb_wr = 1'b0, hw_rd = 1'b0;
    logic [2:0]  pcmd = 3'h0;
    logic [5:0]  fl_idx;
    logic [4:0]  exp_cause = 5'h00;
    expri_src_t  src = '0;
    expri_rfw_t  rf_wr = '0;
    int          failures = 0;
    int          n_tests = 0;
    // far side and unit; read indices fixed at the entries under test
    expri_eic_model #(.HANDLER(HND)) i_eic (.cmd(pcmd), .hw_break(brk),
        .eic_nmi(nmi), .eic_irq(irq), .eic_handler(hdl));
    expri_unit i_dut (.clk(clk), .srst(srst), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
        .cpu_reset_req(cpu_rst), .hw_break(brk), .irq_internal(irq_int),
        .eic_nmi(nmi), .eic_irq(irq), .eic_handler(hdl), .inst_valid(iv),
        .src(src), .rf_wr(rf_wr), .rf_rd_en(rd_en), .rf_rd_idx(5'd5),
        .tlb_wr(tlb_wr), .tlb_wr_idx(6'd9), .tlb_hw_rd(hw_rd),
        .tlb_rd_idx(6'd9), .exc_take(take), .exc_vector(vec),
        .utlb_flush(fl), .utlb_flush_idx(fl_idx));
    initial forever #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (failures == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // classic cycle: hold until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [3:0] a, s,
                      input logic [31:0] d);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wd <= d;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        q = rdat;
        cyc <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, m);
        wb(1'b0, a, 4'hF, 32'h0);
        chk($sformatf("reg %0d", a), e, q & m);
    endtask
    task automatic rfw(input logic [4:0] i);
        rf_wr <= {1'b1, i, 32'hC3C3_0F0F};
        @(posedge clk);
        rf_wr <= '0;
        @(posedge clk);
    endtask
    // one-cycle burst of sources; the unit answers at the sampling edge
    task automatic fire(input logic [11:0] m, input logic [31:0] ev,
                        input logic [4:0] ec, input logic wc);
        pcmd <= {m[4], m[3], m[0]};
        // bit1 cpu reset, bit2 internal irq, bit10 rf read, bit11 tlb read
        {cpu_rst, irq_int, iv, rd_en, hw_rd} <= {m[1], m[2], |m[11:5],
                                                 m[10], m[11]};
        src <= {m[5], m[6], m[7], m[8], m[9], 20'h5A5A5, 32'h0000_1000};
        @(posedge clk);
        {pcmd, cpu_rst, irq_int, iv, rd_en, hw_rd} <= 8'h00;
        src <= '0;
        #1;
        chk("exc_take", 32'h1, {31'h0, take});
        chk("exc_vector", ev, vec);
        @(posedge clk);
        if (wc) exp_cause = ec;
        rd(`EXPRI_ADR_CAUSE, {27'h0, exp_cause}, '1);
    endtask
    task automatic pie();
        wb(1'b1, `EXPRI_ADR_STATUS, 4'hF, 32'h0080_0001);
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        failures++;
        complete_run();
    end
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        #1;
        chk("reset vector", 32'h0, take ? vec : 32'hFFFF_FFFF);
        @(posedge clk);
        rd(`EXPRI_ADR_STATUS, `EXPRI_STATUS_RST, '1);
        rd(`EXPRI_ADR_INJECT, 32'h0, '1);
        rd(`EXPRI_ADR_CAUSE, 32'h0, '1);
        fire(12'h3FF, BA, 5'h00, 1'b0);
        fire(12'h3FE, 32'h0, `EXPRI_C_CPURST, 1'b1);
        pie();
        fire(12'h3FC, EA, `EXPRI_C_IRQ, 1'b1);
        pie();
        fire(12'h3F8, HND, 5'h00, 1'b0);
        pie();
        fire(12'h3F0, HND, `EXPRI_C_IRQ, 1'b1);
        fire(12'h3E0, EA, `EXPRI_C_TLBECC, 1'b1);
        fire(12'h3C0, EA, `EXPRI_C_SUPI, 1'b1);
        pie();
        fire(12'h380, FA, `EXPRI_C_TLBMISS, 1'b1);
        rd(`EXPRI_ADR_VPN, 32'h0005_A5A5, '1);
        fire(12'h380, EA, `EXPRI_C_TLBMISS, 1'b1);
        fire(12'h300, EA, `EXPRI_C_XPERM, 1'b1);
        fire(12'h200, EA, `EXPRI_C_MPUI, 1'b1);
        fire(12'h001, BA, 5'h00, 1'b0);
        // register file: r0 write must leave the field armed
        wb(1'b1, `EXPRI_ADR_INJECT, 4'h1, {30'h0, `EXPRI_INJ_DOUBLE});
        rfw(5'd0);
        rd(`EXPRI_ADR_INJECT, 32'h2, '1);
        rfw(5'd5);
        rd(`EXPRI_ADR_INJECT, 32'h0, '1);
        fire(12'h600, EA, `EXPRI_C_RFECC, 1'b1);
        rd(`EXPRI_ADR_RETADDR, 32'h0000_1000, '1);
        // tlb entry 9 corrupted, then read by software and by hardware
        wb(1'b1, `EXPRI_ADR_INJECT, 4'h1, {28'h0, `EXPRI_INJ_DOUBLE, 2'h0});
        tlb_wr <= 1'b1;
        @(posedge clk);
        tlb_wr <= 1'b0;
        #1;
        chk("utlb_flush", 32'h9, fl ? {26'h0, fl_idx} : 32'h0);
        @(posedge clk);
        rd(`EXPRI_ADR_INJECT, 32'h0, '1);
        wb(1'b1, `EXPRI_ADR_TLB_MISC_CONTROL, 4'h1, 32'h1);
        rd(`EXPRI_ADR_TLB_MISC_CONTROL, 32'h2, 32'h2);
        fire(12'h800, EA, `EXPRI_C_TLBECC, 1'b1);
        complete_run();
    end
endmodule
